// ==== verilog/fsc_defines.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef FSC_DEFINES_SVH
`define FSC_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FSC_ADDR_CLKGEN 9'h020
`define FSC_ADDR_CORE 9'h028
`define FSC_ADDR_FE 9'h030
`define FSC_ADDR_SER 9'h070
`define FSC_ADDR_ART_LO 9'h080
`define FSC_ADDR_ART_HI 9'h096
`define FSC_ADDR_SEQ 9'h0c0
`define FSC_ADDR_WIN 9'h0c3
`define FSC_ADDR_BLACK 9'h0c5
`define FSC_ADDR_DUMMY 9'h0c6
`define FSC_ADDR_EXPO 9'h0c7
`define FSC_ADDR_GAIN 9'h0cc
`define FSC_ADDR_SYNC 9'h0ce

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSC_SEQ_EN 0
`define FSC_SEQ_MODE_LO 1
`define FSC_SEQ_MODE_HI 6
`define FSC_SEQ_RS 1
`define FSC_SEQ_TRIG 2
`define FSC_SEQ_SLAVE 3
`define FSC_SEQ_SUBS 7
`define FSC_SEQ_BIN 8
`define FSC_EXPO_GAIN_ALIGN 13
`define FSC_SYNC_BLACK 1
`define FSC_SYNC_DUMMY 2
`define FSC_SYNC_EXPO 3
`define FSC_SYNC_GAIN 4
`define FSC_SYNC_ROI 5
`define FSC_SYNC_BLANK_ROI 8
`define FSC_SYNC_EXPO_IMM 9

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define FSC_RST_WORD 16'h0000
`define FSC_RST_SYNC 16'h003e
`define FSC_ART_WORDS 23
`define FSC_SPI_ADDR_BITS 9
`define FSC_SPI_FRAME_BITS 26
`define FSC_FRAME_TIME_US 1000
`define FSC_CLK_MHZ 10

`endif

// ==== verilog/fsc_pkg.sv ====
// Shared types of the frame-synchronised configuration block
package fsc_pkg;
    typedef logic [15:0] fsc_word_t;
    typedef logic [8:0] fsc_addr_t;
    typedef enum logic {FSC_IDLE, FSC_RUN} fsc_frame_state_t;
endpackage : fsc_pkg

// ==== verilog/fsc_spi_slave.sv ====
// Serial register port: pin synchronisers, frame shifter, read-back
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defines.svh"
module fsc_spi_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pins
    input wire logic sclk,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    // Register side
    output fsc_pkg::fsc_addr_t addr,
    output logic wr_en,
    output fsc_pkg::fsc_word_t wr_data,
    input wire fsc_pkg::fsc_word_t rd_data
);
    import fsc_pkg::*;

    logic [2:0] sclk_sync;
    logic [2:0] ss_sync;
    logic [2:0] mosi_sync;
    logic sclk_q;
    logic ss_q;
    logic mosi_q;
    logic sclk_prev;
    logic [4:0] bit_cnt;
    logic is_write;
    logic [15:0] rx;
    logic [15:0] tx;
    logic rise;
    logic fall;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // A change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sclk_sync <= 3'h0;
            ss_sync <= 3'h7;
            mosi_sync <= 3'h0;
            sclk_q <= 1'b0;
            ss_q <= 1'b1;
            mosi_q <= 1'b0;
            sclk_prev <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk};
            ss_sync <= {ss_sync[1:0], ss_n};
            mosi_sync <= {mosi_sync[1:0], mosi};
            if (sclk_sync[1] == sclk_sync[2]) begin
                sclk_q <= sclk_sync[2];
            end
            if (ss_sync[1] == ss_sync[2]) begin
                ss_q <= ss_sync[2];
            end
            if (mosi_sync[1] == mosi_sync[2]) begin
                mosi_q <= mosi_sync[2];
            end
            sclk_prev <= sclk_q;
        end
    end

    assign rise = sclk_q && !sclk_prev && !ss_q;
    assign fall = !sclk_q && sclk_prev && !ss_q;

    // ----------------------------------------
    // Frame shifter
    // ----------------------------------------
    // Frame: 9 address bits, 1 write bit, 16 data bits, MSB first
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bit_cnt <= 5'h00;
            is_write <= 1'b0;
            rx <= 16'h0000;
            addr <= 9'h000;
            wr_en <= 1'b0;
            wr_data <= 16'h0000;
        end else begin
            wr_en <= 1'b0;
            if (ss_q) begin
                bit_cnt <= 5'h00;
            end else if (rise) begin
                rx <= {rx[14:0], mosi_q};
                bit_cnt <= bit_cnt + 5'h01;
                if (bit_cnt == 5'(`FSC_SPI_ADDR_BITS - 1)) begin
                    addr <= {rx[7:0], mosi_q};
                end
                if (bit_cnt == 5'(`FSC_SPI_ADDR_BITS)) begin
                    is_write <= mosi_q;
                end
                if (bit_cnt == 5'(`FSC_SPI_FRAME_BITS - 1) && is_write) begin
                    wr_data <= {rx[14:0], mosi_q};
                    wr_en <= 1'b1;
                end
            end
        end
    end

    // Read data loads once a read is seen
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tx <= 16'h0000;
            miso <= 1'b0;
        end else if (ss_q) begin
            miso <= 1'b0;
        end else if (fall) begin
            if (bit_cnt == 5'(`FSC_SPI_ADDR_BITS + 1) && !is_write) begin
                miso <= rd_data[15];
                tx <= {rd_data[14:0], 1'b0};
            end else begin
                miso <= tx[15];
                tx <= {tx[14:0], 1'b0};
            end
        end
    end
endmodule : fsc_spi_slave
`default_nettype wire

// ==== verilog/fsc_frame_timer.sv ====
// Frame period generator driven by the sequencer enable
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defines.svh"
module fsc_frame_timer #(
    parameter int FRAME_CYCLES = `FSC_FRAME_TIME_US * `FSC_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Control
    input wire logic run,
    output logic sof
);
    import fsc_pkg::*;

    fsc_frame_state_t state;
    logic [31:0] cnt;

    initial begin
        if (FRAME_CYCLES < 2) begin
            $error("FRAME_CYCLES must be at least 2");
        end
    end

    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------
    // First frame starts the cycle after enable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= FSC_IDLE;
            cnt <= 32'h0;
            sof <= 1'b0;
        end else begin
            sof <= 1'b0;
            case (state)
                FSC_IDLE: begin
                    cnt <= 32'h0;
                    if (run) begin
                        state <= FSC_RUN;
                        sof <= 1'b1;
                    end
                end
                FSC_RUN: begin
                    if (!run) begin
                        state <= FSC_IDLE;
                    end else if (cnt == 32'(FRAME_CYCLES - 1)) begin
                        cnt <= 32'h0;
                        sof <= 1'b1;
                    end else begin
                        cnt <= cnt + 32'h1;
                    end
                end
                default: begin
                    state <= FSC_IDLE;
                end
            endcase
        end
    end
endmodule : fsc_frame_timer
`default_nettype wire

// ==== verilog/fsc_config_update.sv ====
// Register bank with frame-synchronised active copies and frame blanking
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defines.svh"
// How it works
// [R1] Host changes static setup only while stopped.
// [R2] Mode field changes only while stopped.
// [R3] Host leaves reserved registers at their defaults.
// [R4] Frame writes while running apply at next frame start.
// [R5] A frame needing settling is blanked with training patterns.
// [R6] Subsampling and binning change only at frame start.
// [R7] Line count change blanks one rolling shutter frame.
// [R8] Rolling with blank-on-switch blanks one frame on window switch.
// [R9] Only a changed window selection counts as a switch.
// [R10] Resizing the active window never blanks.
// [R11] Exposure lags one frame unless immediate in master triggered global.
// [R12] Gain applies at the start of the next frame.
// [R13] Align bit delays gain one more frame to match exposure.
// [R14] Black level setup applies at once, acquisition goes on.
// [R15] Sync code writes may spoil the current frame only.
// [R16] Test pattern writes may spoil one frame only.
// [R17] Artifact-prone settings never stop acquisition.
// [R18] Sequencer enable starts frames; clearing it stops and idles.
// [R19] Unsynchronised group keeps its frozen active copy.
// [R20] Written copies move to active copies at frame start.
// [R21] A blank lasts one frame, then normal output resumes.
module fsc_config_update #(
    parameter int FRAME_CYCLES = `FSC_FRAME_TIME_US * `FSC_CLK_MHZ
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Serial register port
    input wire logic SPI_SCLK,
    input wire logic SPI_SS_N,
    input wire logic SPI_MOSI,
    output logic SPI_MISO,
    // Frame context
    output logic SEQ_RUNNING,
    output logic FRAME_START,
    output logic BLANK_FRAME,
    // Active configuration
    output logic [5:0] ACTIVE_MODE,
    output logic ACTIVE_SUBSAMPLE,
    output logic ACTIVE_BINNING,
    output fsc_pkg::fsc_word_t ACTIVE_WINDOW,
    output fsc_pkg::fsc_word_t ACTIVE_BLACK_LINES,
    output fsc_pkg::fsc_word_t ACTIVE_DUMMY_LINES,
    output fsc_pkg::fsc_word_t ACTIVE_EXPOSURE,
    output fsc_pkg::fsc_word_t ACTIVE_GAIN
);
    import fsc_pkg::*;

    fsc_addr_t addr;
    logic wr_en;
    fsc_word_t wr_data;
    fsc_word_t rd_data;
    logic sof;
    fsc_word_t clock_generator_config;
    fsc_word_t image_core_config;
    fsc_word_t front_end_config;
    fsc_word_t serial_transmitter_config;
    fsc_word_t sequencer_control;
    fsc_word_t active_window_select;
    fsc_word_t black_line_config;
    fsc_word_t dummy_line_config;
    fsc_word_t exposure_config;
    fsc_word_t gain_config;
    fsc_word_t frame_sync_options;
    fsc_word_t artifact_regs [0:`FSC_ART_WORDS-1];
    fsc_word_t exposure_stage;
    fsc_word_t gain_stage;
    logic run;
    logic rolling;
    logic expo_immediate;
    logic win_switch;
    logic lines_changed;

    initial begin
        if (FRAME_CYCLES < 2) begin
            $error("FRAME_CYCLES must be at least 2");
        end
    end

    // ----------------------------------------
    // Serial port and frame timing
    // ----------------------------------------
    fsc_spi_slave u_spi (
        .clk(CLK),
        .resetn(RESETN),
        .sclk(SPI_SCLK),
        .ss_n(SPI_SS_N),
        .mosi(SPI_MOSI),
        .miso(SPI_MISO),
        .addr(addr),
        .wr_en(wr_en),
        .wr_data(wr_data),
        .rd_data(rd_data)
    );

    fsc_frame_timer #(
        .FRAME_CYCLES(FRAME_CYCLES)
    ) u_timer (
        .clk(CLK),
        .resetn(RESETN),
        .run(run),
        .sof(sof)
    );

    assign run = sequencer_control[`FSC_SEQ_EN]; // [R18]
    assign rolling = sequencer_control[`FSC_SEQ_RS];
    // Master triggered global: triggered, not slave, not rolling
    assign expo_immediate = frame_sync_options[`FSC_SYNC_EXPO_IMM] && sequencer_control[`FSC_SEQ_TRIG]
        && !sequencer_control[`FSC_SEQ_SLAVE] && !rolling;
    // Rewriting the same selection, or resizing a window, is no switch
    assign win_switch = frame_sync_options[`FSC_SYNC_ROI] && active_window_select != ACTIVE_WINDOW; // [R9] [R10]
    assign lines_changed = (frame_sync_options[`FSC_SYNC_BLACK] && black_line_config != ACTIVE_BLACK_LINES)
        || (frame_sync_options[`FSC_SYNC_DUMMY] && dummy_line_config != ACTIVE_DUMMY_LINES);

    // ----------------------------------------
    // Read-back decode
    // ----------------------------------------
    function automatic fsc_word_t read_reg(input fsc_addr_t a);
        fsc_word_t v;
        v = 16'h0000;
        if (a == `FSC_ADDR_CLKGEN) begin
            v = clock_generator_config;
        end else if (a == `FSC_ADDR_CORE) begin
            v = image_core_config;
        end else if (a == `FSC_ADDR_FE) begin
            v = front_end_config;
        end else if (a == `FSC_ADDR_SER) begin
            v = serial_transmitter_config;
        end else if (a >= `FSC_ADDR_ART_LO && a <= `FSC_ADDR_ART_HI) begin
            v = artifact_regs[5'(a - `FSC_ADDR_ART_LO)];
        end else if (a == `FSC_ADDR_SEQ) begin
            v = sequencer_control;
        end else if (a == `FSC_ADDR_WIN) begin
            v = active_window_select;
        end else if (a == `FSC_ADDR_BLACK) begin
            v = black_line_config;
        end else if (a == `FSC_ADDR_DUMMY) begin
            v = dummy_line_config;
        end else if (a == `FSC_ADDR_EXPO) begin
            v = exposure_config;
        end else if (a == `FSC_ADDR_GAIN) begin
            v = gain_config;
        end else if (a == `FSC_ADDR_SYNC) begin
            v = frame_sync_options;
        end
        return v;
    endfunction : read_reg

    always_comb rd_data = read_reg(addr);

    // ----------------------------------------
    // Written copies
    // ----------------------------------------
    // Static setup stored as written; holding it still is the host's job
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            clock_generator_config <= `FSC_RST_WORD;
            image_core_config <= `FSC_RST_WORD;
            front_end_config <= `FSC_RST_WORD;
            serial_transmitter_config <= `FSC_RST_WORD;
            sequencer_control <= `FSC_RST_WORD;
            active_window_select <= `FSC_RST_WORD;
            black_line_config <= `FSC_RST_WORD;
            dummy_line_config <= `FSC_RST_WORD;
            exposure_config <= `FSC_RST_WORD;
            gain_config <= `FSC_RST_WORD;
            frame_sync_options <= `FSC_RST_SYNC;
        end else if (wr_en) begin
            if (addr == `FSC_ADDR_CLKGEN) begin
                clock_generator_config <= wr_data;
            end else if (addr == `FSC_ADDR_CORE) begin
                image_core_config <= wr_data;
            end else if (addr == `FSC_ADDR_FE) begin
                front_end_config <= wr_data;
            end else if (addr == `FSC_ADDR_SER) begin
                serial_transmitter_config <= wr_data;
            end else if (addr == `FSC_ADDR_SEQ) begin
                sequencer_control <= wr_data;
                // Mode field is locked while frames run
                if (run) begin
                    sequencer_control[`FSC_SEQ_MODE_HI:`FSC_SEQ_MODE_LO] <=
                        sequencer_control[`FSC_SEQ_MODE_HI:`FSC_SEQ_MODE_LO]; // [R2]
                end
            end else if (addr == `FSC_ADDR_WIN) begin
                active_window_select <= wr_data;
            end else if (addr == `FSC_ADDR_BLACK) begin
                black_line_config <= wr_data;
            end else if (addr == `FSC_ADDR_DUMMY) begin
                dummy_line_config <= wr_data;
            end else if (addr == `FSC_ADDR_EXPO) begin
                exposure_config <= wr_data;
            end else if (addr == `FSC_ADDR_GAIN) begin
                gain_config <= wr_data;
            end else if (addr == `FSC_ADDR_SYNC) begin
                frame_sync_options <= wr_data;
            end
        end
    end

    // Black level, sync code and test pattern setup act at once
    // Only a transient frame may suffer; acquisition is not touched
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            for (int i = 0; i < `FSC_ART_WORDS; i++) begin
                artifact_regs[i] <= `FSC_RST_WORD;
            end
        end else if (wr_en && addr >= `FSC_ADDR_ART_LO && addr <= `FSC_ADDR_ART_HI) begin
            artifact_regs[5'(addr - `FSC_ADDR_ART_LO)] <= wr_data; // [R14] [R15] [R16] [R17]
        end
    end

    // ----------------------------------------
    // Frame context outputs
    // ----------------------------------------
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            SEQ_RUNNING <= 1'b0;
            FRAME_START <= 1'b0;
            ACTIVE_MODE <= 6'h00;
        end else begin
            SEQ_RUNNING <= run; // [R18]
            FRAME_START <= sof;
            ACTIVE_MODE <= sequencer_control[`FSC_SEQ_MODE_HI:`FSC_SEQ_MODE_LO];
        end
    end

    // ----------------------------------------
    // Blanking
    // ----------------------------------------
    // Decided afresh at every frame start, so a blank lasts one frame
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            BLANK_FRAME <= 1'b0;
        end else if (!run) begin
            BLANK_FRAME <= 1'b0;
        end else if (sof) begin
            BLANK_FRAME <= rolling && (lines_changed
                || (frame_sync_options[`FSC_SYNC_BLANK_ROI] && win_switch)); // [R5] [R7] [R8] [R21]
        end
    end

    // ----------------------------------------
    // Readout geometry
    // ----------------------------------------
    // Idle: copies follow at once; running: only at frame start
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ACTIVE_WINDOW <= `FSC_RST_WORD;
            ACTIVE_SUBSAMPLE <= 1'b0;
            ACTIVE_BINNING <= 1'b0;
        end else if ((!run || sof) && frame_sync_options[`FSC_SYNC_ROI]) begin
            ACTIVE_WINDOW <= active_window_select; // [R4] [R20] [R19]
            ACTIVE_SUBSAMPLE <= sequencer_control[`FSC_SEQ_SUBS]; // [R6]
            ACTIVE_BINNING <= sequencer_control[`FSC_SEQ_BIN]; // [R6]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            ACTIVE_BLACK_LINES <= `FSC_RST_WORD;
            ACTIVE_DUMMY_LINES <= `FSC_RST_WORD;
        end else if (!run || sof) begin
            if (frame_sync_options[`FSC_SYNC_BLACK]) begin
                ACTIVE_BLACK_LINES <= black_line_config; // [R4] [R19] [R20]
            end
            if (frame_sync_options[`FSC_SYNC_DUMMY]) begin
                ACTIVE_DUMMY_LINES <= dummy_line_config; // [R4] [R19] [R20]
            end
        end
    end

    // ----------------------------------------
    // Exposure and gain pipelines
    // ----------------------------------------
    // Stage holds last frame's value to build the one-frame lag
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            exposure_stage <= `FSC_RST_WORD;
            ACTIVE_EXPOSURE <= `FSC_RST_WORD;
        end else if (!run) begin
            if (frame_sync_options[`FSC_SYNC_EXPO]) begin
                exposure_stage <= exposure_config;
                ACTIVE_EXPOSURE <= exposure_config;
            end
        end else if (sof && frame_sync_options[`FSC_SYNC_EXPO]) begin
            exposure_stage <= exposure_config; // [R20]
            ACTIVE_EXPOSURE <= expo_immediate ? exposure_config : exposure_stage; // [R11] [R19]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            gain_stage <= `FSC_RST_WORD;
            ACTIVE_GAIN <= `FSC_RST_WORD;
        end else if (!run) begin
            if (frame_sync_options[`FSC_SYNC_GAIN]) begin
                gain_stage <= gain_config;
                ACTIVE_GAIN <= gain_config;
            end
        end else if (sof && frame_sync_options[`FSC_SYNC_GAIN]) begin
            gain_stage <= gain_config; // [R20]
            // Align trades a frame of gain latency for pairing with exposure
            ACTIVE_GAIN <= exposure_config[`FSC_EXPO_GAIN_ALIGN] ? gain_stage : gain_config; // [R12] [R13] [R19]
        end
    end
endmodule : fsc_config_update
`default_nettype wire

// ==== verif/fsc_config_update_props.sv ====
// Checker of the frame-synchronised configuration outputs
`timescale 1ns/1ps
`default_nettype none
module fsc_config_update_props #(
    parameter int FRAME_CYCLES = 20
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // Observed outputs
    input wire logic SEQ_RUNNING,
    input wire logic FRAME_START,
    input wire logic BLANK_FRAME,
    input wire logic [5:0] ACTIVE_MODE,
    input wire fsc_pkg::fsc_word_t ACTIVE_WINDOW,
    input wire fsc_pkg::fsc_word_t ACTIVE_EXPOSURE,
    input wire fsc_pkg::fsc_word_t ACTIVE_GAIN
);
    import fsc_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    int gap;
    logic seen;
    // Period trusted after one full frame
    always_ff @(posedge CLK) begin
        gap <= (!RESETN || FRAME_START) ? 0 : gap + 1;
        seen <= RESETN && SEQ_RUNNING && (seen || FRAME_START);
    end
    frame_pulse_a: assert property (FRAME_START |=> !FRAME_START)
        else $error("frame start wider than one cycle");
    frame_period_a: assert property (FRAME_START && seen |-> gap == FRAME_CYCLES - 1)
        else $error("frame period wrong");
    idle_quiet_a: assert property (!SEQ_RUNNING [*3] |-> !FRAME_START)
        else $error("frame start while stopped");
    mode_static_a: assert property ($past(SEQ_RUNNING) && SEQ_RUNNING |-> $stable(ACTIVE_MODE))
        else $error("mode changed while running");
    blank_edge_a: assert property (SEQ_RUNNING && $changed(BLANK_FRAME) |-> FRAME_START)
        else $error("blank changed off frame start");
    blank_rolling_a: assert property (BLANK_FRAME |-> ACTIVE_MODE[0])
        else $error("blank in global shutter");
    window_sync_a: assert property (SEQ_RUNNING && $changed(ACTIVE_WINDOW) |-> FRAME_START)
        else $error("window changed off frame start");
    gain_sync_a: assert property (SEQ_RUNNING && $changed(ACTIVE_GAIN) |-> FRAME_START)
        else $error("gain changed off frame start");
    expo_sync_a: assert property (SEQ_RUNNING && $changed(ACTIVE_EXPOSURE) |-> FRAME_START)
        else $error("exposure changed off frame start");
    cover property ($rose(BLANK_FRAME));
    cover property (FRAME_START && seen);
    cover property (SEQ_RUNNING && $changed(ACTIVE_GAIN));
endmodule : fsc_config_update_props
bind fsc_config_update fsc_config_update_props #(.FRAME_CYCLES(FRAME_CYCLES)) u_props (.CLK, .RESETN,
    .SEQ_RUNNING, .FRAME_START, .BLANK_FRAME, .ACTIVE_MODE, .ACTIVE_WINDOW, .ACTIVE_EXPOSURE, .ACTIVE_GAIN);
`default_nettype wire

// ==== verif/fsc_spi_host.sv ====
// Host model driving serial register frames
`timescale 1ns/1ps
`default_nettype none
module fsc_spi_host (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic sclk,
    output logic ss_n,
    output logic mosi,
    input wire logic miso
);
    initial begin
        sclk = 1'b0;
        ss_n = 1'b1;
        mosi = 1'b0;
    end
    // 6-cycle halves outlast the pin synchroniser
    // Static setup only when stopped; the bench writes unmapped 9'h001 once
    task automatic xfer(input logic [8:0] a, input logic rw, input logic [15:0] d, output logic [15:0] q);
        logic [25:0] f;
        f = {a, rw, d};
        q = 16'h0000;
        @(posedge clk);
        ss_n <= 1'b0;
        for (int i = 25; i >= 0; i--) begin
            mosi <= f[i];
            repeat (6) @(posedge clk);
            sclk <= 1'b1;
            q = {q[14:0], miso};
            repeat (6) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (6) @(posedge clk);
        ss_n <= 1'b1;
        mosi <= ~f[0];
        repeat (6) @(posedge clk);
    endtask : xfer
endmodule : fsc_spi_host
`default_nettype wire

// ==== verif/test_fsc_config_update.sv ====
// Self-checking bench of the configuration update block
`timescale 1ns/1ps
`default_nettype none
`include "fsc_defines.svh"
module test_fsc_config_update;
    import fsc_pkg::*;
    localparam int FC = 1000;
    typedef struct {fsc_addr_t a; fsc_word_t d; int sel; int nfr; fsc_word_t old; fsc_word_t exp;} fsc_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic sclk, ss_n, mosi, miso, run, fs, blank, subs, bin;
    logic [5:0] mode;
    fsc_word_t win, blk, dum, expo, gain, q;
    int n_mismatch = 0, compares = 0, cyc = 0, k;
    fsc_row_t rows[8] = '{
        '{`FSC_ADDR_WIN, 16'h0002, 0, 1, 16'h0000, 16'h0002},
        '{`FSC_ADDR_BLACK, 16'h0011, 1, 1, 16'h0000, 16'h0011},
        '{`FSC_ADDR_DUMMY, 16'h0007, 2, 1, 16'h0000, 16'h0007},
        '{`FSC_ADDR_GAIN, 16'h0033, 4, 1, 16'h0000, 16'h0033},
        '{`FSC_ADDR_EXPO, 16'h0123, 3, 2, 16'h0000, 16'h0123},
        '{`FSC_ADDR_EXPO, 16'h2000, 3, 2, 16'h0123, 16'h2000},
        '{`FSC_ADDR_GAIN, 16'h0044, 4, 2, 16'h0033, 16'h0044},
        '{`FSC_ADDR_SEQ, 16'h0181, 5, 1, 16'h0000, 16'h0003}};
    fsc_config_update #(.FRAME_CYCLES(FC)) u_fsc_config_update (.CLK(clk), .RESETN(resetn), .SPI_SCLK(sclk),
        .SPI_SS_N(ss_n), .SPI_MOSI(mosi), .SPI_MISO(miso), .SEQ_RUNNING(run), .FRAME_START(fs),
        .BLANK_FRAME(blank), .ACTIVE_MODE(mode), .ACTIVE_SUBSAMPLE(subs), .ACTIVE_BINNING(bin),
        .ACTIVE_WINDOW(win), .ACTIVE_BLACK_LINES(blk), .ACTIVE_DUMMY_LINES(dum), .ACTIVE_EXPOSURE(expo),
        .ACTIVE_GAIN(gain));
    fsc_spi_host u_fsc_spi_host (.clk, .sclk, .ss_n, .mosi, .miso);
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc > 90000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input fsc_word_t seen, input fsc_word_t exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input fsc_addr_t a, input fsc_word_t d);
        u_fsc_spi_host.xfer(a, 1'b1, d, q);
    endtask : wr
    // Bounded wait, sampled at falling edge
    task automatic sof(input int n);
        repeat (n) begin
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (fs !== 1'b1 && k < FC + 8);
            if (k >= FC + 8) chk("frame_start", 16'h0000, 16'h0001);
        end
    endtask : sof
    function automatic fsc_word_t pick(input int s);
        case (s)
            0: return win;
            1: return blk;
            2: return dum;
            3: return expo;
            4: return gain;
            default: return {14'h0000, bin, subs};
        endcase
    endfunction : pick
    initial begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        u_fsc_spi_host.xfer(`FSC_ADDR_SYNC, 1'b0, 16'h0000, q);
        chk("sync_reset", q, `FSC_RST_SYNC);
        wr(9'h001, 16'hffff);
        u_fsc_spi_host.xfer(9'h001, 1'b0, 16'h0000, q);
        chk("unmapped", q, 16'h0000);
        wr(`FSC_ADDR_SEQ, 16'h0001);
        sof(1);
        chk("running", run, 16'h0001);
        foreach (rows[i]) begin
            sof(1);
            wr(rows[i].a, rows[i].d);
            for (int f = 0; f < rows[i].nfr; f++) begin
                chk("held", pick(rows[i].sel), rows[i].old);
                sof(1);
            end
            chk("applied", pick(rows[i].sel), rows[i].exp);
            chk("no_blank", blank, 16'h0000);
            $display("row %0d done", i);
        end
        wr(`FSC_ADDR_SEQ, 16'h0180);
        wr(`FSC_ADDR_SEQ, 16'h0183);
        sof(1);
        wr(`FSC_ADDR_BLACK, 16'h0022);
        sof(1);
        chk("blank_black", blank, 16'h0001);
        sof(1);
        chk("blank_end", blank, 16'h0000);
        chk("black", blk, 16'h0022);
        wr(`FSC_ADDR_SYNC, 16'h013e);
        wr(`FSC_ADDR_WIN, 16'h0004);
        sof(1);
        chk("blank_win", blank, 16'h0001);
        sof(1);
        wr(`FSC_ADDR_WIN, 16'h0004);
        sof(1);
        chk("same_win", blank, 16'h0000);
        $display("blanking done");
        wr(`FSC_ADDR_SEQ, 16'h0181);
        sof(1);
        chk("mode_kept", mode, 16'h0001);
        wr(`FSC_ADDR_SYNC, 16'h012e);
        wr(`FSC_ADDR_GAIN, 16'h0055);
        sof(3);
        chk("frozen", gain, 16'h0044);
        wr(`FSC_ADDR_SYNC, 16'h013e);
        sof(2);
        chk("thawed", gain, 16'h0055);
        wr(`FSC_ADDR_SEQ, 16'h0000);
        wr(`FSC_ADDR_GAIN, 16'h0066);
        chk("stopped", run, 16'h0000);
        chk("follow", gain, 16'h0066);
        k = 0;
        repeat (2 * FC) begin
            @(negedge clk);
            if (fs) k++;
        end
        chk("idle_frames", k[15:0], 16'h0000);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (16) @(negedge clk);
        chk("gain_rst", gain, 16'h0000);
        $display("control done");
        close_out();
    end
endmodule : test_fsc_config_update
`default_nettype wire
